// *** shared/uis_consts.svh ***
`ifndef UIS_CONSTS_SVH
`define UIS_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UIS_A_DATA 3'h0
`define UIS_A_IER 3'h1
`define UIS_A_ISR 3'h2
`define UIS_A_LCR 3'h3
`define UIS_A_MCR 3'h4
`define UIS_A_LSR 3'h5
`define UIS_A_MSR 3'h6
`define UIS_A_SPR 3'h7
`define UIS_ENH_KEY 8'hBF
`define UIS_ZERO8 8'h00

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define UIS_LCR_DIV 7
`define UIS_MCR_DTR 0
`define UIS_MCR_RTS 1
`define UIS_MCR_OP1 2
`define UIS_MCR_OP2 3
`define UIS_MCR_LOOP 4
`define UIS_MCR_IR 6
`define UIS_IER_SLEEP 4
`define UIS_FEATURE_CONTROL_IRINV 2
`define UIS_FEATURE_CONTROL_SPRSEL 6
`define UIS_EFR_ENH 4
`define UIS_ISR_NOINT 0
`define UIS_IER_ENH_MASK 8'hF0
`define UIS_MCR_ENH_MASK 8'hE0

// ----------------------------------------
// Infrared timing in 1/16 bit ticks
// ----------------------------------------
`define UIS_IR_PULSE 4'h3
`define UIS_IR_LAST 4'hF

// ----------------------------------------
// Identity codes, values arbitrary
// ----------------------------------------
`define UIS_REVISION 8'h01
`define UIS_DEVICE_ID 8'h5A

`endif

// *** shared/uis_pkg.sv ***
package uis_pkg;

  typedef enum logic [1:0]
  {
    UIS_AWAKE = 2'b01,
    UIS_ASLEEP = 2'b10
  } uis_pwr_t;

endpackage

// *** core/uis_sync2.sv ***
module uis_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk)
  begin
    meta_q <= din;
    sync_q <= meta_q;
  end

  assign dout = sync_q;

endmodule

// *** core/uis_ir_codec.sv ***
`include "uis_consts.svh"

module uis_ir_codec (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick16,
  input wire logic ir_en,
  input wire logic invert,
  input wire logic tx_bit,
  input wire logic rx_line,
  output logic ir_tx,
  output logic ir_rx
);

  logic [3:0] tx_cnt_q;
  logic tx_prev_q;
  logic ir_tx_q;
  logic [3:0] rx_cnt_q;
  logic ir_rx_q;
  logic pulse;

  // ----------------------------------------
  // Encoder: 3/16 pulse per zero bit
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || !ir_en)
    begin
      tx_cnt_q <= 4'h0;
      tx_prev_q <= 1'b1;
      ir_tx_q <= 1'b0;
    end
    else
    begin
      tx_prev_q <= tx_bit;
      if (tx_bit != tx_prev_q)
        tx_cnt_q <= 4'h0;
      else if (tick16)
        tx_cnt_q <= tx_cnt_q + 4'h1;
      ir_tx_q <= !tx_bit && (tx_bit != tx_prev_q || tx_cnt_q < `UIS_IR_PULSE);
    end
  end

  // ----------------------------------------
  // Decoder: pulse held one bit as a one
  // ----------------------------------------
  assign pulse = rx_line ^ invert;

  always_ff @(posedge clk)
  begin
    if (sys_rst || !ir_en)
    begin
      rx_cnt_q <= 4'h0;
      ir_rx_q <= 1'b0;
    end
    else if (pulse)
    begin
      rx_cnt_q <= 4'h0;
      ir_rx_q <= 1'b1;
    end
    else if (tick16 && ir_rx_q)
    begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      if (rx_cnt_q == `UIS_IR_LAST)
        ir_rx_q <= 1'b0;
    end
  end

  assign ir_tx = ir_tx_q;
  assign ir_rx = ir_rx_q;

endmodule

// *** core/uis_channel.sv ***
`include "uis_consts.svh"

module uis_channel (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr_pin,
  input wire logic [7:0] data_in,
  input wire logic cs_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic fifo_status_select_n,
  input wire logic rx_pin,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic cd_n,
  input wire logic ri_n,
  input wire logic tsr_out,
  input wire logic baud_tick16,
  input wire logic [7:0] rx_holding,
  input wire logic [7:0] interrupt_status,
  input wire logic [7:0] line_status,
  input wire logic [7:0] fifo_level,
  input wire logic [7:0] fifo_level_count_enh,
  input wire logic [7:0] fifo_status,
  input wire logic peer_sleep_ok,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic tx_pin,
  output logic rts_n,
  output logic dtr_n,
  output logic op1_n,
  output logic op2_n,
  output logic rsr_in,
  output logic tx_load,
  output logic [7:0] tx_holding,
  output logic rx_read,
  output logic fifo_control_wr,
  output logic [7:0] fifo_control,
  output logic trigger_wr,
  output logic [7:0] fifo_trigger_level,
  output logic [7:0] line_control,
  output logic [7:0] interrupt_enable,
  output logic [7:0] modem_control,
  output logic [15:0] baud_divisor,
  output logic [7:0] feature_control,
  output logic [7:0] enhanced_function,
  output logic [7:0] enhanced_mode_select,
  output logic [7:0] flow_on_char1,
  output logic [7:0] flow_on_char2,
  output logic [7:0] flow_off_char1,
  output logic [7:0] flow_off_char2,
  output logic chan_sleep_ok,
  output logic osc_enable
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [19:0] pins_s;
  logic [2:0] addr_s;
  logic [7:0] din_s;
  logic cs_n_s;
  logic ior_n_s;
  logic iow_n_s;
  logic fsel_n_s;
  logic rx_s;
  logic [3:0] modem_n_s;

  uis_sync2 #(.W(20)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({addr_pin, data_in, cs_n, ior_n, iow_n, fifo_status_select_n, rx_pin, cd_n, ri_n, dsr_n, cts_n}),
    .dout(pins_s)
  );

  assign {addr_s, din_s, cs_n_s, ior_n_s, iow_n_s, fsel_n_s, rx_s, modem_n_s} = pins_s;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] lcr_q;
  logic [7:0] ier_q;
  logic [7:0] mcr_q;
  logic [7:0] dll_q;
  logic [7:0] dlm_q;
  logic [7:0] spr_q;
  logic [7:0] feature_control_q;
  logic [7:0] efr_q;
  logic [7:0] enhanced_mode_select_q;
  logic [7:0] xon1_q;
  logic [7:0] xon2_q;
  logic [7:0] xoff1_q;
  logic [7:0] xoff2_q;
  logic [7:0] thr_q;
  logic [7:0] fcr_q;
  logic [7:0] trg_q;
  logic [3:0] delta_q;
  logic [3:0] modem_prev_q;
  logic ior_prev_q;
  logic iow_prev_q;
  logic rx_prev_q;
  logic [7:0] dout_q;
  logic oe_q;
  logic tx_load_q;
  logic rx_read_q;
  logic fcr_wr_q;
  logic trg_wr_q;
  logic tx_pin_q;
  logic rts_n_q;
  logic dtr_n_q;
  logic op1_n_q;
  logic op2_n_q;
  logic rsr_in_q;
  logic sleep_ok_q;
  logic wake_hold_q;
  uis_pkg::uis_pwr_t pwr_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic rd_start;
  logic wr_start;
  logic enh_map;
  logic div_map;
  logic div_zero;
  logic enh_ok;
  logic loop_en;
  logic ir_en;
  logic [3:0] modem_in;
  logic [7:0] msr_val;
  logic [7:0] rd_data;
  logic ir_tx;
  logic ir_rx;
  logic wake;
  logic local_ok;

  assign rd_start = !cs_n_s && !ior_n_s && ior_prev_q;
  assign wr_start = !cs_n_s && !iow_n_s && iow_prev_q;
  assign enh_map = lcr_q == `UIS_ENH_KEY;
  assign div_map = lcr_q[`UIS_LCR_DIV] && !enh_map;
  assign div_zero = dll_q == `UIS_ZERO8 && dlm_q == `UIS_ZERO8;
  assign enh_ok = efr_q[`UIS_EFR_ENH];
  assign loop_en = mcr_q[`UIS_MCR_LOOP];
  assign ir_en = mcr_q[`UIS_MCR_IR];

  // Modem inputs as active-high status {cd, ri, dsr, cts}
  assign modem_in = loop_en ? {mcr_q[`UIS_MCR_OP2], mcr_q[`UIS_MCR_OP1], mcr_q[`UIS_MCR_DTR],
                               mcr_q[`UIS_MCR_RTS]} : ~modem_n_s;
  assign msr_val = {modem_in, delta_q};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ior_prev_q <= 1'b1;
      iow_prev_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      ior_prev_q <= ior_n_s;
      iow_prev_q <= iow_n_s;
      rx_prev_q <= rx_s;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    rd_data = `UIS_ZERO8;
    if (!fsel_n_s)
      rd_data = fifo_status;
    else if (enh_map)
    begin
      unique case (addr_s)
        `UIS_A_DATA: rd_data = fifo_level_count_enh;
        `UIS_A_IER: rd_data = feature_control_q;
        `UIS_A_ISR: rd_data = efr_q;
        `UIS_A_LCR: rd_data = lcr_q;
        `UIS_A_MCR: rd_data = xon1_q;
        `UIS_A_LSR: rd_data = xon2_q;
        `UIS_A_MSR: rd_data = xoff1_q;
        `UIS_A_SPR: rd_data = xoff2_q;
      endcase
    end
    else
    begin
      unique case (addr_s)
        `UIS_A_DATA: rd_data = !div_map ? rx_holding : div_zero ? `UIS_REVISION : dll_q;
        `UIS_A_IER: rd_data = !div_map ? ier_q : div_zero ? `UIS_DEVICE_ID : dlm_q;
        `UIS_A_ISR: rd_data = interrupt_status;
        `UIS_A_LCR: rd_data = lcr_q;
        `UIS_A_MCR: rd_data = mcr_q;
        `UIS_A_LSR: rd_data = line_status;
        `UIS_A_MSR: rd_data = msr_val;
        `UIS_A_SPR: rd_data = feature_control_q[`UIS_FEATURE_CONTROL_SPRSEL] ? fifo_level : spr_q;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dout_q <= `UIS_ZERO8;
      oe_q <= 1'b0;
      rx_read_q <= 1'b0;
    end
    else
    begin
      if (rd_start)
        dout_q <= rd_data;
      oe_q <= !cs_n_s && !ior_n_s;
      rx_read_q <= rd_start && fsel_n_s && !enh_map && !div_map && addr_s == `UIS_A_DATA;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lcr_q <= `UIS_ZERO8;
      ier_q <= `UIS_ZERO8;
      mcr_q <= `UIS_ZERO8;
      dll_q <= `UIS_ZERO8;
      dlm_q <= `UIS_ZERO8;
      spr_q <= `UIS_ZERO8;
      feature_control_q <= `UIS_ZERO8;
      efr_q <= `UIS_ZERO8;
      enhanced_mode_select_q <= `UIS_ZERO8;
      xon1_q <= `UIS_ZERO8;
      xon2_q <= `UIS_ZERO8;
      xoff1_q <= `UIS_ZERO8;
      xoff2_q <= `UIS_ZERO8;
      thr_q <= `UIS_ZERO8;
      fcr_q <= `UIS_ZERO8;
      trg_q <= `UIS_ZERO8;
      tx_load_q <= 1'b0;
      fcr_wr_q <= 1'b0;
      trg_wr_q <= 1'b0;
    end
    else
    begin
      tx_load_q <= 1'b0;
      fcr_wr_q <= 1'b0;
      trg_wr_q <= 1'b0;
      if (wr_start && enh_map)
      begin
        unique case (addr_s)
          `UIS_A_DATA:
          begin
            trg_q <= din_s;
            trg_wr_q <= 1'b1;
          end
          `UIS_A_IER: feature_control_q <= din_s;
          `UIS_A_ISR: efr_q <= din_s;
          `UIS_A_LCR: lcr_q <= din_s;
          `UIS_A_MCR: xon1_q <= din_s;
          `UIS_A_LSR: xon2_q <= din_s;
          `UIS_A_MSR: xoff1_q <= din_s;
          `UIS_A_SPR: xoff2_q <= din_s;
        endcase
      end
      else if (wr_start)
      begin
        unique case (addr_s)
          `UIS_A_DATA:
          begin
            if (div_map)
              dll_q <= din_s;
            else
            begin
              thr_q <= din_s;
              tx_load_q <= 1'b1;
            end
          end
          `UIS_A_IER:
          begin
            if (div_map)
              dlm_q <= din_s;
            else if (enh_ok)
              ier_q <= din_s;
            else
              ier_q <= (ier_q & `UIS_IER_ENH_MASK) | (din_s & ~`UIS_IER_ENH_MASK);
          end
          `UIS_A_ISR:
          begin
            fcr_q <= din_s;
            fcr_wr_q <= 1'b1;
          end
          `UIS_A_LCR: lcr_q <= din_s;
          `UIS_A_MCR:
          begin
            if (enh_ok)
              mcr_q <= din_s;
            else
              mcr_q <= (mcr_q & `UIS_MCR_ENH_MASK) | (din_s & ~`UIS_MCR_ENH_MASK);
          end
          `UIS_A_SPR:
          begin
            if (feature_control_q[`UIS_FEATURE_CONTROL_SPRSEL])
              enhanced_mode_select_q <= din_s;
            else
              spr_q <= din_s;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Modem change indications
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      delta_q <= 4'h0;
      modem_prev_q <= 4'h0;
    end
    else
    begin
      modem_prev_q <= modem_in;
      if (rd_start && fsel_n_s && !enh_map && addr_s == `UIS_A_MSR)
        delta_q <= modem_in ^ modem_prev_q;
      else
        delta_q <= delta_q | (modem_in ^ modem_prev_q);
    end
  end

  // ----------------------------------------
  // Serial path, infrared and loopback
  // ----------------------------------------
  uis_ir_codec u_ir (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick16(baud_tick16),
    .ir_en(ir_en),
    .invert(feature_control_q[`UIS_FEATURE_CONTROL_IRINV]),
    .tx_bit(tsr_out),
    .rx_line(rx_s),
    .ir_tx(ir_tx),
    .ir_rx(ir_rx)
  );

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_pin_q <= 1'b1;
      rsr_in_q <= 1'b1;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
      op1_n_q <= 1'b1;
      op2_n_q <= 1'b1;
    end
    else
    begin
      if (loop_en)
      begin
        tx_pin_q <= 1'b1;
        rsr_in_q <= tsr_out;
        rts_n_q <= 1'b1;
        dtr_n_q <= 1'b1;
        op1_n_q <= 1'b1;
        op2_n_q <= 1'b1;
      end
      else
      begin
        tx_pin_q <= ir_en ? ir_tx : tsr_out;
        rsr_in_q <= ir_en ? ir_rx : rx_s;
        rts_n_q <= !mcr_q[`UIS_MCR_RTS];
        dtr_n_q <= !mcr_q[`UIS_MCR_DTR];
        op1_n_q <= !mcr_q[`UIS_MCR_OP1];
        op2_n_q <= !mcr_q[`UIS_MCR_OP2];
      end
    end
  end

  // ----------------------------------------
  // Sleep and wake-up
  // ----------------------------------------
  assign local_ok = interrupt_status[`UIS_ISR_NOINT] && ier_q[`UIS_IER_SLEEP] &&
                    delta_q == 4'h0 && rx_s;
  assign wake = (rx_prev_q && !rx_s) || tx_load_q ||
                (modem_in != modem_prev_q);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pwr_q <= uis_pkg::UIS_AWAKE;
      sleep_ok_q <= 1'b0;
      wake_hold_q <= 1'b0;
    end
    else
    begin
      sleep_ok_q <= local_ok;
      wake_hold_q <= wake;
      unique case (pwr_q)
        uis_pkg::UIS_AWAKE:
          if (sleep_ok_q && local_ok && peer_sleep_ok && !wake && !wake_hold_q)
            pwr_q <= uis_pkg::UIS_ASLEEP;
        uis_pkg::UIS_ASLEEP:
          if (wake || !ier_q[`UIS_IER_SLEEP])
            pwr_q <= uis_pkg::UIS_AWAKE;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign data_out = dout_q;
  assign data_oe = oe_q;
  assign tx_pin = tx_pin_q;
  assign rts_n = rts_n_q;
  assign dtr_n = dtr_n_q;
  assign op1_n = op1_n_q;
  assign op2_n = op2_n_q;
  assign rsr_in = rsr_in_q;
  assign tx_load = tx_load_q;
  assign tx_holding = thr_q;
  assign rx_read = rx_read_q;
  assign fifo_control_wr = fcr_wr_q;
  assign fifo_control = fcr_q;
  assign trigger_wr = trg_wr_q;
  assign fifo_trigger_level = trg_q;
  assign line_control = lcr_q;
  assign interrupt_enable = ier_q;
  assign modem_control = mcr_q;
  assign baud_divisor = {dlm_q, dll_q};
  assign feature_control = feature_control_q;
  assign enhanced_function = efr_q;
  assign enhanced_mode_select = enhanced_mode_select_q;
  assign flow_on_char1 = xon1_q;
  assign flow_on_char2 = xon2_q;
  assign flow_off_char1 = xoff1_q;
  assign flow_off_char2 = xoff2_q;
  assign chan_sleep_ok = sleep_ok_q;
  assign osc_enable = pwr_q == uis_pkg::UIS_AWAKE;

endmodule

// *** verification/uis_channel_properties.sv ***
module uis_channel_properties (
  input logic clk,
  input logic sys_rst,
  input logic rx_pin,
  input logic cts_n,
  input logic tsr_out,
  input logic peer_sleep_ok,
  input logic tx_pin,
  input logic rts_n,
  input logic dtr_n,
  input logic rsr_in,
  input logic tx_load,
  input logic [7:0] modem_control,
  input logic [7:0] interrupt_enable,
  input logic [7:0] feature_control,
  input logic chan_sleep_ok,
  input logic osc_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Quiet-line counters for infrared mode
  // ----------------------------------------
  logic ir_on;
  logic [5:0] txq_q;
  logic [5:0] rxq_q;
  assign ir_on = modem_control[6] && !modem_control[4];
  always_ff @(posedge clk)
  begin
    if (sys_rst || !ir_on || !tsr_out)
      txq_q <= 6'h00;
    else if (txq_q != 6'h3F)
      txq_q <= txq_q + 6'h01;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || !ir_on || (rx_pin ^ feature_control[2]))
      rxq_q <= 6'h00;
    else if (rxq_q != 6'h3F)
      rxq_q <= rxq_q + 6'h01;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  loop_tx_mark_a: assert property (modem_control[4] && $past(modem_control[4]) |-> tx_pin)
    else $error("loopback transmit pin not at mark");
  loop_modem_off_a: assert property (modem_control[4] && $past(modem_control[4]) |-> rts_n && dtr_n)
    else $error("loopback modem outputs asserted");
  loop_feed_a: assert property (modem_control[4] && $past(modem_control[4], 2) && $stable(tsr_out) |-> rsr_in == tsr_out)
    else $error("loopback receive input not fed from transmitter");
  ir_tx_idle_a: assert property (txq_q >= 6'h28 |-> !tx_pin)
    else $error("infrared transmit not idle low");
  ir_pulse_len_a: assert property (ir_on && $rose(tx_pin) |-> tx_pin[*6] ##[1:2] !tx_pin)
    else $error("infrared pulse width wrong");
  ir_rx_idle_a: assert property (rxq_q >= 6'h28 |-> !rsr_in)
    else $error("infrared decoded data not idle low");
  sleep_entry_a: assert property ($fell(osc_enable) |-> $past(chan_sleep_ok) && $past(peer_sleep_ok) && interrupt_enable[4])
    else $error("sleep entered without conditions");
  sleep_disable_a: assert property (!osc_enable && !interrupt_enable[4] |-> ##[0:3] osc_enable)
    else $error("sleep kept after enable cleared");
  wake_rx_a: assert property (!osc_enable && !modem_control[4] && $fell(rx_pin) |-> ##[1:4] osc_enable)
    else $error("no wake on receive start");
  wake_modem_a: assert property (!osc_enable && !modem_control[4] && $changed(cts_n) |-> ##[1:4] osc_enable)
    else $error("no wake on modem change");
  wake_load_a: assert property (tx_load |-> ##[0:2] osc_enable)
    else $error("no wake on transmit load");
endmodule

bind uis_channel uis_channel_properties uis_channel_properties_i (.*);

// *** verification/uis_far_end.sv ***
module uis_far_end (
  input logic clk,
  input logic tx_pin,
  output logic rx_pin,
  output logic cts_n,
  output logic dsr_n,
  output logic cd_n,
  output logic ri_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_q = 1'b1;
  logic prev_q = 1'b1;
  int pulses = 0;
  // Marking line, modem lines negated
  initial {rx_pin, cts_n, dsr_n, cd_n, ri_n} = 5'h1F;
  // Light pulses seen from the transmitter
  always @(posedge clk)
  begin
    if (tx_pin && !prev_q)
      pulses <= pulses + 1;
    prev_q <= tx_pin;
  end
  // Dark line for infrared, mark for serial
  task set_idle(input logic lvl);
    @(posedge clk);
    idle_q = lvl;
    rx_pin <= lvl;
  endtask
  task pulse(input int n);
    @(posedge clk);
    rx_pin <= ~idle_q;
    repeat (n) @(posedge clk);
    rx_pin <= idle_q;
  endtask
  task flip();
    @(posedge clk);
    cts_n <= ~cts_n;
  endtask
endmodule

// *** verification/tb.sv ***
`include "uis_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, cs_n, ior_n, iow_n, fifo_status_select_n, tsr_out, baud_tick16, peer_sleep_ok;
  logic rx_pin, cts_n, dsr_n, cd_n, ri_n, data_oe, tx_pin, rts_n, dtr_n, op1_n, op2_n, rsr_in, tx_load;
  logic rx_read, fifo_control_wr, trigger_wr, chan_sleep_ok, osc_enable;
  logic [2:0] addr_pin;
  logic [7:0] data_in, rx_holding, interrupt_status, line_status, fifo_level, fifo_level_count_enh, fifo_status;
  logic [7:0] data_out, tx_holding, fifo_control, fifo_trigger_level, line_control, interrupt_enable;
  logic [7:0] modem_control, feature_control, enhanced_function, enhanced_mode_select;
  logic [7:0] flow_on_char1, flow_on_char2, flow_off_char1, flow_off_char2, v, w, q;
  logic [15:0] baud_divisor;
  int mismatches = 0, cmp_count = 0, n_load = 0, n_rsr = 0, n_wake = 0, k;
  logic osc_prev = 1'b1;

  uis_channel uis_channel_i (.*);
  uis_far_end uis_far_end_i (.*);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    baud_tick16 <= ~baud_tick16;
    n_load <= n_load + int'(tx_load);
    n_rsr <= n_rsr + int'(rsr_in);
    n_wake <= n_wake + int'(osc_enable && !osc_prev);
    osc_prev <= osc_enable;
  end

  // ----------------------------------------
  // Checking and host bus tasks
  // ----------------------------------------
  task give_verdict();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    addr_pin <= a;
    data_in <= d;
    cs_n <= 1'b0;
    iow_n <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    iow_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task rd(input logic [2:0] a, output logic [7:0] d);
    addr_pin <= a;
    cs_n <= 1'b0;
    ior_n <= 1'b0;
    repeat (4) @(posedge clk);
    d = data_out;
    chk(16'(data_oe), 16'h0001);
    cs_n <= 1'b1;
    ior_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task rdc(input logic [2:0] a, input logic [7:0] e);
    rd(a, q);
    chk(16'(q), 16'(e));
  endtask

  task wait_osc(input logic lvl);
    for (int i = 0; i < 2000 && osc_enable !== lvl; i++) @(posedge clk);
    if (osc_enable !== lvl)
    begin
      mismatches++;
      give_verdict();
    end
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {sys_rst, cs_n, ior_n, iow_n, fifo_status_select_n, tsr_out, baud_tick16, peer_sleep_ok} = 8'hFE;
    {addr_pin, data_in} = 11'h000;
    {rx_holding, interrupt_status, line_status, fifo_level, fifo_level_count_enh, fifo_status} = 48'h0;
    v = 8'($urandom(32'h794F));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(`UIS_A_LCR, 8'h00);
    for (k = 0; k < 3; k++)
    begin
      v = 8'($urandom);
      if (k == 0) rx_holding <= v;
      if (k == 1) interrupt_status <= v;
      if (k == 2) line_status <= v;
      rdc((k == 0) ? `UIS_A_DATA : (k == 1) ? `UIS_A_ISR : `UIS_A_LSR, v);
    end
    wr(`UIS_A_IER, 8'hFF);
    rdc(`UIS_A_IER, 8'h0F);
    v = 8'($urandom);
    wr(`UIS_A_SPR, v);
    rdc(`UIS_A_SPR, v);
    wr(`UIS_A_LCR, 8'h80);
    v = 8'($urandom) | 8'h01;
    w = 8'($urandom);
    wr(3'h0, v);
    wr(3'h1, w);
    rdc(3'h0, v);
    chk(baud_divisor, {w, v});
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    rdc(3'h0, `UIS_REVISION);
    rdc(3'h1, `UIS_DEVICE_ID);
    wr(`UIS_A_LCR, `UIS_ENH_KEY);
    wr(3'h2, 8'h10);
    rdc(3'h2, 8'h10);
    for (k = 4; k < 8; k++)
    begin
      v = 8'($urandom);
      wr(3'(k), v);
      rdc(3'(k), v);
    end
    v = 8'($urandom);
    fifo_level_count_enh <= v;
    rdc(3'h0, v);
    wr(3'h0, w);
    chk(16'(fifo_trigger_level), 16'(w));
    wr(3'h1, 8'h40);
    rdc(3'h1, 8'h40);
    wr(`UIS_A_LCR, 8'h00);
    fifo_level <= v;
    rdc(`UIS_A_SPR, v);
    wr(`UIS_A_SPR, w);
    chk(16'(enhanced_mode_select), 16'(w));
    wr(`UIS_A_IER, 8'hF0);
    chk(16'(interrupt_enable), 16'h00F0);
    v = 8'($urandom);
    fifo_status <= v;
    fifo_status_select_n <= 1'b0;
    rdc(3'($urandom), v);
    fifo_status_select_n <= 1'b1;
    wr(`UIS_A_ISR, w);
    chk(16'(fifo_control), 16'(w));
    chk(16'(line_control), 16'h0000);
    k = n_load;
    wr(`UIS_A_DATA, w);
    chk(16'(tx_holding), 16'(w));
    chk(16'(n_load - k), 16'h0001);
    wr(`UIS_A_MCR, 8'h0F);
    chk({rts_n, dtr_n, op1_n, op2_n}, 4'h0);
    wr(`UIS_A_MCR, 8'h1F);
    chk(16'(modem_control), 16'h001F);
    uis_far_end_i.flip();
    chk({tx_pin, rts_n, dtr_n}, 3'h7);
    for (k = 0; k < 30; k++) @(posedge clk) tsr_out <= 1'($urandom);
    tsr_out <= 1'b1;
    rd(`UIS_A_MSR, q);
    chk(q[7:4], 4'hF);
    rdc(`UIS_A_MSR, {4'hF, 4'h0});
    wr(`UIS_A_MCR, 8'h40);
    uis_far_end_i.set_idle(1'b0);
    repeat (45) @(posedge clk);
    chk(tx_pin, 1'b0);
    k = uis_far_end_i.pulses;
    tsr_out <= 1'b0;
    repeat (64) @(posedge clk);
    tsr_out <= 1'b1;
    repeat (45) @(posedge clk);
    chk(uis_far_end_i.pulses != k, 1'b1);
    k = n_rsr;
    uis_far_end_i.pulse(6);
    repeat (40) @(posedge clk);
    chk(n_rsr != k, 1'b1);
    wr(`UIS_A_LCR, `UIS_ENH_KEY);
    wr(3'h1, 8'h04);
    wr(`UIS_A_LCR, 8'h00);
    uis_far_end_i.set_idle(1'b1);
    repeat (45) @(posedge clk);
    k = n_rsr;
    uis_far_end_i.pulse(6);
    repeat (40) @(posedge clk);
    chk(n_rsr != k, 1'b1);
    wr(`UIS_A_MCR, 8'h00);
    interrupt_status <= 8'h01;
    peer_sleep_ok <= 1'b1;
    wr(`UIS_A_IER, 8'h10);
    rd(`UIS_A_MSR, q);
    wait_osc(1'b0);
    chk(osc_enable, 1'b0);
    chk(chan_sleep_ok, 1'b1);
    k = n_wake;
    uis_far_end_i.pulse(20);
    chk(n_wake != k, 1'b1);
    wait_osc(1'b0);
    chk(osc_enable, 1'b0);
    uis_far_end_i.flip();
    wait_osc(1'b1);
    rd(`UIS_A_MSR, q);
    wait_osc(1'b0);
    chk(osc_enable, 1'b0);
    k = n_wake;
    wr(`UIS_A_DATA, v);
    chk(n_wake != k, 1'b1);
    wait_osc(1'b0);
    wr(`UIS_A_IER, 8'h00);
    repeat (50) @(posedge clk);
    chk(osc_enable, 1'b1);
    give_verdict();
  end
endmodule
